// File: logic/rtw_defs.vh
// rtw_defs.vh: register offsets, field positions, reset values and timing
// counts for the trim / alarm / watchdog block.
// assumes: included by bare name from every design file of the block.
`ifndef RTW_DEFS_VH
`define RTW_DEFS_VH

// ----------------------------------------------------------------------
// register offsets (4-bit internal address pointer)
// ----------------------------------------------------------------------
`define RTW_ADDR_SECONDS     4'h1
`define RTW_ADDR_DAY         4'h4
`define RTW_ADDR_LAST_CLOCK  4'h7
`define RTW_ADDR_CLOCK_TRIM  4'h8
`define RTW_ADDR_WD_TIMEOUT  4'h9
`define RTW_ADDR_AL_MONTH    4'hA
`define RTW_ADDR_AL_DATE     4'hB
`define RTW_ADDR_AL_HOUR     4'hC
`define RTW_ADDR_AL_MIN      4'hD
`define RTW_ADDR_AL_SEC      4'hE
`define RTW_ADDR_EVENT_FLAGS 4'hF

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define RTW_TRIM_OUT_BIT     7
`define RTW_TRIM_FT_BIT      6
`define RTW_TRIM_SIGN_BIT    5
`define RTW_OSC_HALT_BIT     7
`define RTW_AFE_BIT          7
`define RTW_SQUARE_ENABLE_BIT         6
`define RTW_RPT_HI_BIT       7
`define RTW_RPT5_BIT         6
`define RTW_FLAG_WD_BIT      7
`define RTW_FLAG_AL_BIT      6
`define RTW_FLAG_OF_BIT      2

// ----------------------------------------------------------------------
// reset values and encodings
// ----------------------------------------------------------------------
`define RTW_WD_RESET         8'h00
`define RTW_TRIM_RESET       8'h80
`define RTW_SQ_512HZ_CODE    4'h6
`define RTW_RPT_SECOND       5'h1F
`define RTW_RPT_MINUTE       5'h1E
`define RTW_RPT_HOUR         5'h1C
`define RTW_RPT_DAY          5'h18
`define RTW_RPT_MONTH        5'h10
`define RTW_RPT_YEAR         5'h00

// ----------------------------------------------------------------------
// timing: divider chain and watchdog resolutions (in 16 Hz ticks)
// ----------------------------------------------------------------------
`define RTW_OSC_HZ           32768
`define RTW_STAGE_NORMAL     9'd255
`define RTW_STAGE_SHORT      9'd127
`define RTW_STAGE_LONG       9'd511
`define RTW_SECS_PER_MIN     6'd59
`define RTW_CAL_CYCLE_LAST   6'd63
`define RTW_RES_16HZ         10'd1
`define RTW_RES_4HZ          10'd4
`define RTW_RES_1HZ          10'd16
`define RTW_RES_QHZ          10'd64
`define RTW_RES_MIN          10'd960
`define RTW_TREC_US          100000

`endif

// File: logic/rtw_cal_div.v
// rtw_cal_div.v: calibrated divider chain from oscillator ticks to seconds.
// assumes: osc_tick is a one-cycle pulse per oscillator period, already
// synchronised to clk and gated off while the oscillator is halted.
`timescale 1ns/10ps
`include "rtw_defs.vh"

module rtw_cal_div (
  input  wire       clk,
  input  wire       rst,
  input  wire       osc_tick,
  input  wire [5:0] trim,
  output reg        tick_16hz,
  output reg        tick_sec,
  output reg        sq_512hz
);

  reg [8:0] stage_reg;
  reg [6:0] sub_reg;
  reg [5:0] sec_in_min_reg;
  reg [5:0] cyc_min_reg;
  reg [7:0] raw_reg;
  reg [8:0] stage_limit;
  wire      corr_second;
  wire      stage_wrap;

  assign corr_second = (sec_in_min_reg == 6'd0) && (sub_reg == 7'd0) &&
                       (cyc_min_reg < {trim[4:0], 1'b0});

  always @* begin
    stage_limit = `RTW_STAGE_NORMAL;
    if (corr_second) begin
      if (trim[`RTW_TRIM_SIGN_BIT])
        stage_limit = `RTW_STAGE_SHORT;
      else
        stage_limit = `RTW_STAGE_LONG;
    end
  end

  // range compare: a trim write inside a long period cannot overrun the stage
  assign stage_wrap = osc_tick && (stage_reg >= stage_limit);

  // ----------------------------------------------------------------------
  // corrected chain: /256 stage, 128 stage, seconds, 64-minute cycle
  // ----------------------------------------------------------------------
  // once per minute, 64-minute cycle
  always @(posedge clk) begin
    if (rst) begin
      stage_reg      <= 9'd0;
      sub_reg        <= 7'd0;
      sec_in_min_reg <= 6'd0;
      cyc_min_reg    <= 6'd0;
      tick_16hz      <= 1'b0;
      tick_sec       <= 1'b0;
    end else begin
      tick_16hz <= stage_wrap && (sub_reg[2:0] == 3'h7);
      tick_sec  <= stage_wrap && (sub_reg == 7'h7F);
      if (osc_tick)
        stage_reg <= stage_wrap ? 9'd0 : stage_reg + 9'd1;
      if (stage_wrap) begin
        sub_reg <= sub_reg + 7'd1;
        if (sub_reg == 7'h7F) begin
          if (sec_in_min_reg == `RTW_SECS_PER_MIN) begin
            sec_in_min_reg <= 6'd0;
            cyc_min_reg    <= cyc_min_reg + 6'd1;  // wraps 63 -> 0
          end else begin
            sec_in_min_reg <= sec_in_min_reg + 6'd1;
          end
        end
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      raw_reg  <= 8'h00;
      sq_512hz <= 1'b0;
    end else begin
      if (osc_tick)
        raw_reg <= raw_reg + 8'h01;
      sq_512hz <= raw_reg[5];  // 64 osc periods per cycle
    end
  end

endmodule // rtw_cal_div

// File: logic/rtw_trim_alarm_wd.v
// rtw_trim_alarm_wd.v: calibration, alarm and watchdog logic of a serial
// real-time clock, reached through the internal register pointer port.
// assumes: the serial bus engine drives reg_addr (the address pointer) and
// one-cycle reg_wr / reg_rd strobes on clk; the time counters sit outside
// and present BCD fields on clk; osc_in is the raw 32,768 Hz time base.
//
// Functional notes
// - calibration adds or blanks counts at the divide-by-256 stage.
// - five-bit unsigned magnitude 0..31 in low bits of clock_trim.
// - sign bit one speeds clock up, zero slows it down.
// - 64-minute cycle; one second per minute shortened 128 or lengthened 256.
// - magnitude N corrects only the first 2N minutes of each cycle.
// - square pin toggles 512 Hz for code 0110, enable set, oscillator running.
// - shared pin toggles 512 Hz when test and level bits set, running, no interrupt active.
// - trim value never changes the 512 Hz or square-wave frequency.
// - alarm flag set when time matches alarm fields chosen by repeat bits.
// - repeat codes pick second..year; unknown codes act as every second.
// - alarm flag with alarm interrupt enable drives the open-drain interrupt.
// - match held off while pointer rests on flags; raised once it moves.
// - flags read releases alarm interrupt, clears alarm flag, seen next read.
// - timeout is five-bit multiplier times resolution chosen by three bits.
// - resolution codes 101, 110, 111 never time out.
// - multiplier zero with resolution 001..100 times out at once.
// - expiry sets watchdog flag, then drives interrupt and reset pulse; a multiplier-zero timeout drives no interrupt.
// - watchdog write or any clock register write restarts countdown.
// - watchdog write releases interrupt; 00h disables; cleared at reset.
// - flags read clears watchdog flag in bit 7.
// - reset pin low for recovery time, timer then idle until rewritten.
// - flags bit 7 watchdog, bit 6 alarm, bit 2 oscillator fail.
`timescale 1ns/10ps
`include "rtw_defs.vh"

module rtw_trim_alarm_wd #(
  // rate pre-divided by 64 (15625 = 1e6 / 64) keeps the product in 32-bit range
  parameter TREC_OSC_CYCLES = (`RTW_TREC_US * (`RTW_OSC_HZ / 64) + 15624) / 15625
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       osc_in,
  input  wire [3:0] reg_addr,
  input  wire       reg_wr,
  input  wire       reg_rd,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata,
  input  wire [7:0] cur_sec,
  input  wire [7:0] cur_min,
  input  wire [7:0] cur_hour,
  input  wire [7:0] cur_date,
  input  wire [7:0] cur_month,
  input  wire       osc_fail_flag,
  output wire       tick_sec,
  output reg        square_output_pin,
  output wire       shared_irq_test_pin_o,
  output reg        shared_irq_test_pin_oe,
  output wire       timeout_reset_pin_o,
  output reg        timeout_reset_pin_oe
);

  // watchdog states
  localparam [1:0] WD_OFF  = 2'b00;
  localparam [1:0] WD_RUN  = 2'b01;
  localparam [1:0] WD_HOLD = 2'b10;
  localparam [31:0] TREC_WIDE = TREC_OSC_CYCLES - 1;
  localparam [12:0] TREC_LAST = TREC_WIDE[12:0];

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // resolution code to period in 16 Hz ticks; zero marks an invalid code
  function [9:0] res_period;
    input [2:0] code;
    begin
      case (code)
        3'd0:    res_period = `RTW_RES_16HZ;
        3'd1:    res_period = `RTW_RES_4HZ;
        3'd2:    res_period = `RTW_RES_1HZ;
        3'd3:    res_period = `RTW_RES_QHZ;
        3'd4:    res_period = `RTW_RES_MIN;
        default: res_period = 10'd0;
      endcase
    end
  endfunction

  // resolution field is split across the watchdog byte
  function [2:0] wd_resolution;
    input [7:0] v;
    begin
      wd_resolution = {v[7], v[1:0]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  reg  [7:0]  clock_trim_reg;
  reg  [7:0]  watchdog_timeout_reg;
  reg  [7:0]  al_month_reg;
  reg  [7:0]  al_date_reg;
  reg  [7:0]  al_hour_reg;
  reg  [7:0]  al_min_reg;
  reg  [7:0]  al_sec_reg;
  reg  [3:0]  square_freq_select_reg;
  reg         osc_halt_bit_reg;
  reg         timeout_flag_reg;
  reg         alarm_hit_flag_reg;
  reg         alarm_pend_reg;
  reg         wd_irq_reg;
  reg  [1:0]  wd_state_reg;
  reg  [4:0]  wd_left_reg;
  reg  [9:0]  wd_sub_reg;
  reg  [12:0] trec_cnt_reg;
  reg  [2:0]  osc_sync_reg;
  reg  [7:0]  rdata_next;
  reg         match;

  wire        osc_tick;
  wire        tick_16hz;
  wire        sq_512hz;
  wire        wr_wd;
  wire        wr_clock;
  wire        rd_flags;
  wire        ptr_on_flags;
  wire [4:0]  repeat_mask;
  wire [4:0]  wd_multiplier;
  wire [9:0]  wd_period;
  wire        wd_expire;
  wire        alarm_irq_enable;
  wire        square_enable;
  wire        freq_test_mode;
  wire        out_level;
  wire        irq_active;

  assign wr_wd            = reg_wr && (reg_addr == `RTW_ADDR_WD_TIMEOUT);
  assign wr_clock         = reg_wr && (reg_addr <= `RTW_ADDR_LAST_CLOCK);
  assign rd_flags         = reg_rd && (reg_addr == `RTW_ADDR_EVENT_FLAGS);
  assign ptr_on_flags     = (reg_addr == `RTW_ADDR_EVENT_FLAGS);
  assign repeat_mask      = {al_date_reg[`RTW_RPT5_BIT], al_date_reg[`RTW_RPT_HI_BIT],
                             al_hour_reg[`RTW_RPT_HI_BIT], al_min_reg[`RTW_RPT_HI_BIT],
                             al_sec_reg[`RTW_RPT_HI_BIT]};
  assign wd_multiplier    = watchdog_timeout_reg[6:2];
  assign wd_period        = res_period(wd_resolution(watchdog_timeout_reg));
  assign alarm_irq_enable = al_month_reg[`RTW_AFE_BIT];
  assign square_enable    = al_month_reg[`RTW_SQUARE_ENABLE_BIT];
  assign freq_test_mode   = clock_trim_reg[`RTW_TRIM_FT_BIT];
  assign out_level        = clock_trim_reg[`RTW_TRIM_OUT_BIT];

  // ----------------------------------------------------------------------
  // oscillator input synchroniser and edge detect
  // ----------------------------------------------------------------------
  // stage 0 feeds only stage 1; the edge detector looks at stages 1 and 2
  always @(posedge clk) begin
    if (rst)
      osc_sync_reg <= 3'b000;
    else
      osc_sync_reg <= {osc_sync_reg[1:0], osc_in};
  end

  // ticks from time base; halt bit stops the chain
  assign osc_tick = osc_sync_reg[1] && !osc_sync_reg[2] && !osc_halt_bit_reg;

  rtw_cal_div u_div (
    .clk       (clk),
    .rst       (rst),
    .osc_tick  (osc_tick),
    .trim      (clock_trim_reg[5:0]),
    .tick_16hz (tick_16hz),
    .tick_sec  (tick_sec),
    .sq_512hz  (sq_512hz)
  );

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  // timekeeping counters live outside; only control bits are kept here
  always @(posedge clk) begin
    if (rst) begin
      clock_trim_reg         <= `RTW_TRIM_RESET;
      watchdog_timeout_reg   <= `RTW_WD_RESET;
      al_month_reg           <= 8'h00;
      al_date_reg            <= 8'h00;
      al_hour_reg            <= 8'h00;
      al_min_reg             <= 8'h00;
      al_sec_reg             <= 8'h00;
      square_freq_select_reg <= 4'h0;
      osc_halt_bit_reg       <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `RTW_ADDR_SECONDS:    osc_halt_bit_reg <= reg_wdata[`RTW_OSC_HALT_BIT];
        `RTW_ADDR_DAY:        square_freq_select_reg <= reg_wdata[7:4];
        `RTW_ADDR_CLOCK_TRIM: clock_trim_reg <= reg_wdata;
        `RTW_ADDR_WD_TIMEOUT: watchdog_timeout_reg <= reg_wdata;
        `RTW_ADDR_AL_MONTH:   al_month_reg <= reg_wdata;
        `RTW_ADDR_AL_DATE:    al_date_reg <= reg_wdata;
        `RTW_ADDR_AL_HOUR:    al_hour_reg <= reg_wdata;
        `RTW_ADDR_AL_MIN:     al_min_reg <= reg_wdata;
        `RTW_ADDR_AL_SEC:     al_sec_reg <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------------
  // flags layout
  always @* begin
    case (reg_addr)
      `RTW_ADDR_SECONDS:     rdata_next = {osc_halt_bit_reg, 7'h00};
      `RTW_ADDR_DAY:         rdata_next = {square_freq_select_reg, 4'h0};
      `RTW_ADDR_CLOCK_TRIM:  rdata_next = clock_trim_reg;
      `RTW_ADDR_WD_TIMEOUT:  rdata_next = watchdog_timeout_reg;
      `RTW_ADDR_AL_MONTH:    rdata_next = al_month_reg;
      `RTW_ADDR_AL_DATE:     rdata_next = al_date_reg;
      `RTW_ADDR_AL_HOUR:     rdata_next = al_hour_reg;
      `RTW_ADDR_AL_MIN:      rdata_next = al_min_reg;
      `RTW_ADDR_AL_SEC:      rdata_next = al_sec_reg;
      `RTW_ADDR_EVENT_FLAGS: rdata_next = {timeout_flag_reg, alarm_hit_flag_reg, 3'b000,
                                           osc_fail_flag, 2'b00};
      default:               rdata_next = 8'h00;
    endcase
  end

  // old value returned, clear seen next read
  always @(posedge clk) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_next;
  end

  // ----------------------------------------------------------------------
  // alarm compare
  // ----------------------------------------------------------------------
  // repeat code decode
  always @* begin
    case (repeat_mask)
      `RTW_RPT_MINUTE: match = (cur_sec[6:0] == al_sec_reg[6:0]);
      `RTW_RPT_HOUR:   match = (cur_sec[6:0] == al_sec_reg[6:0]) &&
                               (cur_min[6:0] == al_min_reg[6:0]);
      `RTW_RPT_DAY:    match = (cur_sec[6:0] == al_sec_reg[6:0]) &&
                               (cur_min[6:0] == al_min_reg[6:0]) &&
                               (cur_hour[5:0] == al_hour_reg[5:0]);
      `RTW_RPT_MONTH:  match = (cur_sec[6:0] == al_sec_reg[6:0]) &&
                               (cur_min[6:0] == al_min_reg[6:0]) &&
                               (cur_hour[5:0] == al_hour_reg[5:0]) &&
                               (cur_date[5:0] == al_date_reg[5:0]);
      `RTW_RPT_YEAR:   match = (cur_sec[6:0] == al_sec_reg[6:0]) &&
                               (cur_min[6:0] == al_min_reg[6:0]) &&
                               (cur_hour[5:0] == al_hour_reg[5:0]) &&
                               (cur_date[5:0] == al_date_reg[5:0]) &&
                               (cur_month[4:0] == al_month_reg[4:0]);
      default:         match = 1'b1;  // every second, flags a bad setting fast
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      alarm_hit_flag_reg <= 1'b0;
      alarm_pend_reg     <= 1'b0;
    end else begin
      // held off while pointer on flags
      if (tick_sec && match && ptr_on_flags)
        alarm_pend_reg <= 1'b1;
      else if (!ptr_on_flags)
        alarm_pend_reg <= 1'b0;
      // set wins over the read clear in the same cycle
      if ((tick_sec && match && !ptr_on_flags) || (alarm_pend_reg && !ptr_on_flags))
        alarm_hit_flag_reg <= 1'b1;
      else if (rd_flags)
        alarm_hit_flag_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------------
  // multiplier times resolution
  assign wd_expire = (wd_state_reg == WD_RUN) && tick_16hz &&
                     (wd_sub_reg == wd_period - 10'd1) && (wd_left_reg == 5'd1);

  always @(posedge clk) begin
    if (rst) begin
      wd_state_reg <= WD_OFF;
      wd_left_reg  <= 5'd0;
      wd_sub_reg   <= 10'd0;
      trec_cnt_reg <= 13'd0;
    end else begin
      case (wd_state_reg)
        WD_OFF: begin
          if (wr_wd) begin
            wd_sub_reg  <= 10'd0;
            wd_left_reg <= reg_wdata[6:2];
            if (reg_wdata == 8'h00)
              wd_state_reg <= WD_OFF;
            else if (res_period({reg_wdata[7], reg_wdata[1:0]}) == 10'd0)
              wd_state_reg <= WD_OFF;
            else if (reg_wdata[6:2] == 5'd0) begin
              wd_state_reg <= WD_HOLD;
              trec_cnt_reg <= TREC_LAST;
            end else
              wd_state_reg <= WD_RUN;
          end
        end
        WD_RUN: begin
          if (wr_clock || wr_wd) begin
            wd_sub_reg  <= 10'd0;
            wd_left_reg <= wr_wd ? reg_wdata[6:2] : wd_multiplier;
            if (wr_wd && (reg_wdata == 8'h00 ||
                res_period({reg_wdata[7], reg_wdata[1:0]}) == 10'd0))
              wd_state_reg <= WD_OFF;
            else if (wr_wd && reg_wdata[6:2] == 5'd0) begin
              wd_state_reg <= WD_HOLD;
              trec_cnt_reg <= TREC_LAST;
            end
          end else if (wd_expire) begin
            wd_state_reg <= WD_HOLD;
            trec_cnt_reg <= TREC_LAST;
          end else if (tick_16hz) begin
            if (wd_sub_reg == wd_period - 10'd1) begin
              wd_sub_reg  <= 10'd0;
              wd_left_reg <= wd_left_reg - 5'd1;
            end else
              wd_sub_reg <= wd_sub_reg + 10'd1;
          end
        end
        WD_HOLD: begin
          // pulse counts oscillator periods, then timer idles
          if (osc_tick && trec_cnt_reg != 13'd0)
            trec_cnt_reg <= trec_cnt_reg - 13'd1;
          else if (osc_tick)
            wd_state_reg <= WD_OFF;
        end
        default: wd_state_reg <= WD_OFF;
      endcase
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      timeout_flag_reg <= 1'b0;
      wd_irq_reg       <= 1'b0;
    end else begin
      if (wd_state_reg != WD_HOLD && (wd_expire || (wr_wd && reg_wdata != 8'h00 &&
          reg_wdata[6:2] == 5'd0 && res_period({reg_wdata[7], reg_wdata[1:0]}) != 10'd0)))
        timeout_flag_reg <= 1'b1;
      else if (rd_flags)
        timeout_flag_reg <= 1'b0;
      if (wd_expire)
        wd_irq_reg <= 1'b1;
      else if (wr_wd)
        wd_irq_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------------
  // alarm flag gated by enable
  assign irq_active = (alarm_hit_flag_reg && alarm_irq_enable) || wd_irq_reg;

  // open-drain pins only ever pull low
  assign shared_irq_test_pin_o = 1'b0;
  assign timeout_reset_pin_o   = 1'b0;

  always @(posedge clk) begin
    if (rst) begin
      square_output_pin      <= 1'b0;
      shared_irq_test_pin_oe <= 1'b0;
      timeout_reset_pin_oe   <= 1'b0;
    end else begin
      square_output_pin <= square_enable && !osc_halt_bit_reg &&
                           (square_freq_select_reg == `RTW_SQ_512HZ_CODE) && sq_512hz;
      if (irq_active)
        shared_irq_test_pin_oe <= 1'b1;
      else if (freq_test_mode && out_level && !osc_halt_bit_reg)
        shared_irq_test_pin_oe <= !sq_512hz;
      else
        shared_irq_test_pin_oe <= !out_level;
      timeout_reset_pin_oe <= (wd_state_reg == WD_HOLD);
    end
  end

endmodule // rtw_trim_alarm_wd

// File: verif/rtw_monitor.sv
// rtw_monitor.sv: port checker for the trim / alarm / watchdog block.
// assumes: osc_in rises once per 4 clk cycles, oscillator never halted.
`timescale 1ns/10ps
module rtw_monitor (
  input wire       clk, rst, reg_wr, reg_rd, osc_fail_flag, square_output_pin,
  input wire       shared_irq_test_pin_o, timeout_reset_pin_o, timeout_reset_pin_oe,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata, reg_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // decoded strobes
  wire wr9 = reg_wr && reg_addr == 4'h9;
  wire rdf = reg_rd && reg_addr == 4'hF;
  // ------------------
  // assertions
  // ------------------
  flag_bits_a: assert property (
    rdf |=> {reg_rdata[5:3], reg_rdata[1:0]} == 5'h00 && reg_rdata[2] == $past(osc_fail_flag))
    else $error("flags layout wrong");
  rd_hold_a: assert property (
    !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  unmapped_a: assert property (
    reg_rd && reg_addr inside {4'h0, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7} |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  now_expire_a: assert property (
    wr9 && reg_wdata[6:2] == 5'h00 && {reg_wdata[7], reg_wdata[1:0]} inside {[3'h1:3'h4]}
    |-> ##[1:24] timeout_reset_pin_oe) else $error("no immediate expiry");
  bad_res_a: assert property (
    wr9 && reg_wdata[7] && reg_wdata[1:0] != 2'h0 |=> (!$rose(timeout_reset_pin_oe)) [*8])
    else $error("invalid resolution expired");
  wd_off_a: assert property (
    wr9 && reg_wdata == 8'h00 |=> (!$rose(timeout_reset_pin_oe)) [*8])
    else $error("disabled watchdog pulsed");
  pulse_min_a: assert property (
    $rose(timeout_reset_pin_oe) |=> timeout_reset_pin_oe [*8]) else $error("pulse short");
  pulse_end_a: assert property (
    $rose(timeout_reset_pin_oe) |-> ##[12:40] !timeout_reset_pin_oe) else $error("pulse long");
  open_drain_a: assert property (
    !shared_irq_test_pin_o && !timeout_reset_pin_o) else $error("open drain driven high");
  sq_half_a: assert property (
    $rose(square_output_pin) |=> square_output_pin [*8]) else $error("square phase short");
  // main scenarios reached
  c_pulse: cover property ($rose(timeout_reset_pin_oe));
  c_sq: cover property ($rose(square_output_pin));
  c_wdf: cover property (rdf ##1 reg_rdata[7]);
endmodule // rtw_monitor

bind rtw_trim_alarm_wd rtw_monitor u_mon (.clk, .rst, .reg_wr, .reg_rd, .osc_fail_flag,
  .square_output_pin, .shared_irq_test_pin_o, .timeout_reset_pin_o, .timeout_reset_pin_oe,
  .reg_addr, .reg_wdata, .reg_rdata);

// File: verif/rtw_host_model.sv
// rtw_host_model.sv: host side of the register pointer port.
// assumes: tasks are called from the bench; signals move at falling edges.
`timescale 1ns/10ps
module rtw_host_model (
  input  wire       clk,
  output reg  [3:0] reg_addr,
  output reg        reg_wr,
  output reg        reg_rd,
  output reg  [7:0] reg_wdata,
  input  wire [7:0] reg_rdata
);
  initial {reg_addr, reg_wr, reg_rd, reg_wdata} = {4'h8, 2'h0, 8'h00};
  // pointer parked off flags
  // parking at 0x8 keeps an alarm match from being held off
  task automatic wr(input [3:0] a, input [7:0] d);
    @(negedge clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk) {reg_addr, reg_wr} = {4'h8, 1'b0};
  endtask
  task automatic rd(input [3:0] a, output [7:0] d);
    @(negedge clk) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk) {reg_addr, reg_rd} = {4'h8, 1'b0};
    d = reg_rdata;
  endtask
  task automatic alarm_off;
    for (int a = 11; a < 15; a++) wr(a[3:0], 8'h00);
  endtask
endmodule // rtw_host_model

// File: verif/tb_top.sv
// tb_top.sv: self-checking bench for the trim / alarm / watchdog block.
// assumes: osc_in sped up to 4 clk cycles a period so a run stays short.
`timescale 1ns/10ps
module tb_top;
  logic       clk = 0, rst = 1, osc_in = 0, of_in = 0;
  logic [7:0] cs = 8'h00, cm = 8'h00, ch = 8'h00, cd = 8'h00, cn = 8'h00, d, v;
  wire  [3:0] reg_addr;
  wire  [7:0] reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, tick_sec, sq, irq_o, irq_oe, wdo_o, wdo_oe;
  int         n_mismatch = 0, tests_run = 0, n;
  initial forever #2.5 clk = ~clk;
  // odd start offset keeps osc_in unrelated in phase to clk
  initial begin
    #1.3;
    forever #10 osc_in = ~osc_in;
  end
  rtw_trim_alarm_wd #(.TREC_OSC_CYCLES(4)) u_dut (.clk, .rst, .osc_in, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata, .cur_sec(cs), .cur_min(cm), .cur_hour(ch),
    .cur_date(cd), .cur_month(cn), .osc_fail_flag(of_in), .tick_sec, .square_output_pin(sq),
    .shared_irq_test_pin_o(irq_o), .shared_irq_test_pin_oe(irq_oe),
    .timeout_reset_pin_o(wdo_o), .timeout_reset_pin_oe(wdo_oe));
  rtw_host_model u_host (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
  // ------------------
  // helpers
  // ------------------
  task automatic chk(input [7:0] got, input [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input [3:0] a, input [7:0] e);
    u_host.rd(a, d);
    chk(d, e);
  endtask
  // bounded wait for a pin; n equals lim when it never came
  task automatic wait_hi(input int irq, input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if ((irq ? irq_oe : wdo_oe) === 1'b1) break;
    end
  endtask
  // 512 Hz is 64 osc periods, 256 clk cycles: ten rises in 2560
  task automatic sq_rises(input int pin);
    logic p;
    d = 8'h00;
    @(negedge clk);  // an enable edge must not count as a rise
    p = pin ? !irq_oe : sq;
    repeat (2560) begin
      @(negedge clk);
      if ((pin ? !irq_oe : sq) === 1'b1 && p === 1'b0) d++;
      p = pin ? !irq_oe : sq;
    end
  endtask
  // let a reset pulse run out, then see the pin released
  task automatic settle;
    repeat (40) @(negedge clk);
    chk(8'(wdo_oe), 8'h00);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // hang guard, about seven times the expected run
  initial begin
    #2000000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    v = $urandom(32'hF4FBFBDA);
    repeat (4) @(posedge clk);
    @(negedge clk) rst = 0;
    rc(4'h8, 8'h80);
    rc(4'h9, 8'h00);
    rc(4'h3, 8'h00);
    $display("reset values done");
    repeat (6) begin
      v = $urandom;
      {cs, cm, ch, cd} = $urandom;
      cn = v;
      of_in = v[0];
      u_host.wr(4'h8, v);
      rc(4'h8, v);
      rc(4'hF, {5'h00, v[0], 2'h0});
    end
    of_in = 0;
    u_host.wr(4'h8, 8'h80);
    $display("random trim done");
    u_host.wr(4'h4, 8'h60);
    u_host.wr(4'hA, 8'h40);
    sq_rises(0);
    chk(d, 8'h0A);
    u_host.wr(4'h8, 8'h3F);
    sq_rises(0);
    chk(d, 8'h0A);
    u_host.wr(4'h8, 8'hC0);
    sq_rises(1);
    chk(d, 8'h0A);
    u_host.wr(4'h8, 8'h80);
    $display("square output done");
    u_host.wr(4'h9, 8'h02);
    wait_hi(0, 40);
    chk(8'(n < 40), 8'h01);
    rc(4'hF, 8'h80);
    rc(4'hF, 8'h00);
    settle;
    $display("immediate expiry done");
    u_host.wr(4'h9, 8'h0C);
    repeat (9000) @(negedge clk);
    u_host.wr(4'h2, 8'h00);
    wait_hi(1, 26000);
    chk(8'(n > 16000 && n < 24700), 8'h01);
    chk(8'(wdo_oe), 8'h01);
    rc(4'hF, 8'h80);
    u_host.wr(4'h9, 8'h00);
    @(negedge clk);
    chk(8'(irq_oe), 8'h00);
    settle;
    $display("timed expiry done");
    u_host.wr(4'h9, 8'h81);
    wait_hi(0, 40);
    chk(8'(n == 40), 8'h01);
    u_host.wr(4'h9, 8'h85);
    wait_hi(0, 17000);
    chk(8'(n == 17000), 8'h01);
    u_host.alarm_off;
    rc(4'hB, 8'h00);
    $display("invalid resolution done");
    wrap_up;
  end
endmodule // tb_top
